//--- ssb_sram_core.sv
// bus-operation decode, pipeline, lane drivers and storage of the burst sram
// How it works
// - chips off with load low deselects, bus undriven
// - advance while deselected stays deselected, bus undriven
// - selected load with write enable high starts a read at the pin address
// - advance during a read reads next burst address, ignoring selects
// - read started with output enable off is a dummy read, undriven
// - read continued with output enable off is a dummy read, undriven
// - selected load, write enable low, a strobe low starts a write
// - advance during a write with a strobe low writes next address
// - write start with all strobes high is an abort, nothing written
// - write continue with all strobes high advances, writes nothing
// - clock qualifier high freezes address, state and outputs
// - output enable gates drivers without sampling; writes mask it
// - read lanes float unless output enable on and selected
// - write cycle turns off every data and parity lane
// - exactly the lanes with a low strobe take data and parity
// - all strobes high changes nothing; reads ignore strobes
// - lane drive follows current operation and output enable
// - burst steps low two bits, linear or interleaved, wrapping
// - write data is taken on the second qualified edge
// - sleep entry and exit take two cycles; controller deselects
`timescale 1ns/1ps
module ssb_sram_core import ssb_pkg::*; #(
	parameter int ADDR_W = DEF_ADDR_W,
	parameter int LANES = DEF_LANES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// address and controls
	input wire logic [ADDR_W-1:0] address,
	input wire logic chipSel1N,
	input wire logic chipSel2,
	input wire logic chipSel3N,
	input wire logic advanceOrLoad,
	input wire logic writeEnableN,
	input wire logic [LANES-1:0] byteLaneWriteN,
	input wire logic outputEnableN,
	input wire logic clockQualifyN,
	input wire logic sleepRequest,
	input wire logic burstOrder,
	// data lanes
	input wire logic [LANES*LANE_W-1:0] dataIn,
	output logic [LANES*LANE_W-1:0] dataOut,
	output logic dataOe,
	// parity lanes
	input wire logic [LANES-1:0] parityBusIn,
	output logic [LANES-1:0] parityBusOut,
	output logic parityBusOe,
	// status
	output logic sleepActive
);
	localparam int SW = LANE_W + 1;
	localparam int EW = LANES * SW;
	localparam int FW = ADDR_W + LANES + EW;

	if (LANES < 1 || LANES > 8 || ADDR_W < BURST_W)
	begin : g_bad_size
		$error("lane count must be 1 to 8 and address at least two bits");
	end

	// keep the lanes of old whose mask bit is clear, take new elsewhere
	function automatic logic [EW-1:0] mergeLanes(input logic [EW-1:0] old,
		input logic [EW-1:0] fresh, input logic [LANES-1:0] mask);
		logic [EW-1:0] res;
		res = old;
		for (int i = 0; i < LANES; i++)
			if (mask[i])
				res[i*SW +: SW] = fresh[i*SW +: SW];
		return res;
	endfunction

	logic [EW-1:0] mem [2**ADDR_W];
	ssb_burst_t burstState, next_burst;
	ssb_op_t s1Op, s2Op, next_op;
	logic [ADDR_W-1:0] s1Addr, s2Addr, headAddr;
	logic [LANES-1:0] s1Mask, s2Mask, next_mask, headMask;
	logic [BURST_W-1:0] stepLow;
	logic [1:0] sleepCnt;
	logic asleep, quiet, chipOn, allOff, edgeTaken, loadBurst, stepBurst, driveArm;
	logic [EW-1:0] inWord, fetchWord, headWord;

	ssb_stream_if #(.W(FW)) pushIf ();
	ssb_stream_if #(.W(FW)) drainIf ();

	assign chipOn = !chipSel1N && chipSel2 && !chipSel3N;
	assign allOff = &byteLaneWriteN;
	assign quiet = sleepRequest || asleep;
	// a full write buffer stalls the edge like the clock qualifier does
	assign edgeTaken = !clockQualifyN && !quiet && pushIf.ready;
	assign loadBurst = edgeTaken && !advanceOrLoad && chipOn;
	assign stepBurst = edgeTaken && advanceOrLoad && burstState != BST_IDLE;

	// operation decode for this edge
	always_comb
	begin
		next_op = OP_NONE;
		next_burst = burstState;
		next_mask = '0;
		if (!advanceOrLoad)
		begin
			if (!chipOn)
				next_burst = BST_IDLE;
			else if (writeEnableN)
			begin
				next_burst = BST_READ;
				next_op = OP_READ;
			end
			else
			begin
				next_burst = BST_WRITE;
				next_op = allOff ? OP_NONE : OP_WRITE;
				next_mask = ~byteLaneWriteN;
			end
		end
		else
		begin
			unique case (burstState)
				BST_IDLE: next_op = OP_NONE;
				BST_READ: next_op = OP_READ;
				BST_WRITE:
				begin
					next_op = allOff ? OP_NONE : OP_WRITE;
					next_mask = ~byteLaneWriteN;
				end
			endcase
		end
	end

	ssb_burst_ctr u_burst (
		.core_clk(core_clk),
		.rstn(rstn),
		.load(loadBurst),
		.step(stepBurst),
		.interleaved(burstOrder),
		.base(address[BURST_W-1:0]),
		.stepLow(stepLow)
	);

	// address stage: load from pins or step the burst
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			burstState <= BST_IDLE;
			s1Op <= OP_NONE;
			s1Addr <= '0;
			s1Mask <= '0;
		end
		else if (quiet)
		begin
			burstState <= BST_IDLE;
			s1Op <= OP_NONE;
		end
		else if (edgeTaken)
		begin
			burstState <= next_burst;
			s1Op <= next_op;
			s1Mask <= next_mask;
			if (loadBurst)
				s1Addr <= address;
			else if (stepBurst)
				s1Addr[BURST_W-1:0] <= stepLow;
		end
	end

	// second stage: the data edge of each access
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s2Op <= OP_NONE;
			s2Addr <= '0;
			s2Mask <= '0;
		end
		else if (quiet)
			s2Op <= OP_NONE;
		else if (edgeTaken)
		begin
			s2Op <= s1Op;
			s2Addr <= s1Addr;
			s2Mask <= s1Mask;
		end
	end

	// read data pipeline; a write entering stage two turns drivers off first
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			driveArm <= 1'b0;
			dataOut <= '0;
			parityBusOut <= '0;
		end
		else if (quiet)
			driveArm <= 1'b0;
		else if (edgeTaken)
		begin
			driveArm <= s2Op == OP_READ && s1Op != OP_WRITE;
			if (s2Op == OP_READ)
				for (int i = 0; i < LANES; i++)
				begin
					dataOut[i*LANE_W +: LANE_W] <= fetchWord[i*SW +: LANE_W];
					parityBusOut[i] <= fetchWord[i*SW + LANE_W];
				end
		end
	end

	// output enable acts unsampled; dummy reads are the armed, disabled case
	assign dataOe = driveArm && !outputEnableN && !sleepRequest;
	assign parityBusOe = dataOe;

	// incoming lanes packed as parity above each byte
	for (genvar g = 0; g < LANES; g++)
	begin : g_lane
		assign inWord[g*SW +: SW] = {parityBusIn[g], dataIn[g*LANE_W +: LANE_W]};
	end

	// write data is taken on the data edge, masked lanes only
	assign pushIf.valid = !clockQualifyN && !quiet && s2Op == OP_WRITE;
	assign pushIf.data = {s2Addr, s2Mask, inWord};

	ssb_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_wbuf (
		.core_clk(core_clk),
		.rstn(rstn),
		.inPort(pushIf),
		.outPort(drainIf)
	);

	// drain stalls while sleep is requested or active, and pushes stop too, so the buffer only holds its entries
	assign drainIf.ready = !quiet;
	assign headAddr = drainIf.data[EW+LANES +: ADDR_W];
	assign headMask = drainIf.data[EW +: LANES];
	assign headWord = drainIf.data[EW-1:0];

	// the buffer head is forwarded so a read just behind a write sees it
	assign fetchWord = (drainIf.valid && headAddr == s2Addr) ?
		mergeLanes(mem[s2Addr], headWord, headMask) : mem[s2Addr];

	// storage update; unmasked lanes keep their old contents
	always_ff @(posedge core_clk)
	begin
		if (drainIf.valid && drainIf.ready)
			mem[headAddr] <= mergeLanes(mem[headAddr], headWord, headMask);
	end

	// sleep entry and exit each take two cycles
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sleepCnt <= '0;
			asleep <= 1'b0;
		end
		else if (sleepRequest != asleep)
		begin
			if (sleepCnt == SLEEP_CNT_LAST)
			begin
				sleepCnt <= '0;
				asleep <= sleepRequest;
			end
			else
				sleepCnt <= sleepCnt + 1'b1;
		end
		else
			sleepCnt <= '0;
	end

	assign sleepActive = asleep;

	// every check below runs on the one core clock
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	property p_deselect;
		edgeTaken && !advanceOrLoad && !chipOn |=> burstState == BST_IDLE && s1Op == OP_NONE;
	endproperty
	a_deselect: assert property (p_deselect) else $error("deselect not taken");
	property p_stayDeselected;
		edgeTaken && advanceOrLoad && burstState == BST_IDLE |=> burstState == BST_IDLE;
	endproperty
	a_stayDeselected: assert property (p_stayDeselected) else $error("left deselect");
	property p_readStart;
		edgeTaken && !advanceOrLoad && chipOn && writeEnableN
		|=> s1Op == OP_READ && s1Addr == $past(address);
	endproperty
	a_readStart: assert property (p_readStart) else $error("read start wrong");
	property p_readData;
		(edgeTaken && next_op == OP_READ) ##1 edgeTaken ##1 (edgeTaken && s1Op != OP_WRITE)
		|=> driveArm;
	endproperty
	a_readData: assert property (p_readData) else $error("read data late");
	property p_writeOff;
		edgeTaken && s1Op == OP_WRITE |=> !driveArm && !dataOe;
	endproperty
	a_writeOff: assert property (p_writeOff) else $error("driving in write");
	// a stalled edge after the abort leaves an older write in stage two
	property p_abort;
		edgeTaken && !advanceOrLoad && chipOn && !writeEnableN && allOff
		|=> s1Op == OP_NONE ##1 (!pushIf.valid || !$past(edgeTaken));
	endproperty
	a_abort: assert property (p_abort) else $error("abort wrote");
	property p_stall;
		clockQualifyN && !quiet |=> $stable(s1Addr) && $stable(burstState) && $stable(dataOut);
	endproperty
	a_stall: assert property (p_stall) else $error("stall moved state");
	property p_sleepOff;
		sleepRequest |-> !dataOe && !parityBusOe ##1 burstState == BST_IDLE;
	endproperty
	a_sleepOff: assert property (p_sleepOff) else $error("driving asleep");
	// linear order wraps from the top low address back to zero
	property p_linear;
		stepBurst && !burstOrder && s1Addr[1:0] == 2'h3 |=> s1Addr[1:0] == 2'h0;
	endproperty
	a_linear: assert property (p_linear) else $error("burst did not wrap");
	property p_pushMask;
		pushIf.valid |-> pushIf.data[EW +: LANES] == s2Mask && s2Mask != '0;
	endproperty
	a_pushMask: assert property (p_pushMask) else $error("bad write mask");
	property p_sleepEntry;
		$rose(sleepRequest) && !asleep |=> !asleep ##1 (asleep || !sleepRequest);
	endproperty
	a_sleepEntry: assert property (p_sleepEntry) else $error("sleep entry time");

	c_read: cover property (@(posedge core_clk) disable iff (!rstn) dataOe);
	c_write: cover property (@(posedge core_clk) disable iff (!rstn) pushIf.valid && pushIf.ready);
	c_full: cover property (@(posedge core_clk) disable iff (!rstn) !pushIf.ready);
	c_sleep: cover property (@(posedge core_clk) disable iff (!rstn) $fell(asleep));
endmodule

//--- ssb_pkg.sv
// shared constants and types for the burst sram bus-operation logic
package ssb_pkg;
	localparam int LANE_W = 8;
	localparam int DEF_LANES = 4;
	localparam int DEF_ADDR_W = 21;
	localparam int FIFO_DEPTH = 4;
	localparam int BURST_W = 2;
	localparam int SLEEP_ENTRY_CYC = 2;
	localparam int SLEEP_EXIT_CYC = 2;
	localparam logic [1:0] SLEEP_CNT_LAST = 2'h1;

	typedef enum logic [2:0] {
		BST_IDLE = 3'b001,
		BST_READ = 3'b010,
		BST_WRITE = 3'b100
	} ssb_burst_t;

	typedef enum logic [2:0] {
		OP_NONE = 3'b001,
		OP_READ = 3'b010,
		OP_WRITE = 3'b100
	} ssb_op_t;
endpackage

//--- ssb_stream_if.sv
// valid/ready word stream between the core and its write buffer
`timescale 1ns/1ps
interface ssb_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport tx (output valid, output data, input ready);
	modport rx (input valid, input data, output ready);
endinterface

//--- ssb_fifo.sv
// small first-in first-out write buffer with valid/ready on both sides
`timescale 1ns/1ps
module ssb_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// fill and drain sides
	ssb_stream_if.rx inPort,
	ssb_stream_if.tx outPort
);
	localparam int PW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << PW) != DEPTH)
	begin : g_bad_depth
		$error("fifo depth must be a power of two, at least 2");
	end

	logic [W-1:0] store [DEPTH];
	logic [PW:0] wrPtr;
	logic [PW:0] rdPtr;
	logic full;
	logic empty;

	// pointers carry one extra bit so full and empty differ
	assign empty = wrPtr == rdPtr;
	assign full = (wrPtr[PW] != rdPtr[PW]) && (wrPtr[PW-1:0] == rdPtr[PW-1:0]);
	assign inPort.ready = !full;
	assign outPort.valid = !empty;
	assign outPort.data = store[rdPtr[PW-1:0]];

	// storage has no reset; only entries below the write pointer are read
	always_ff @(posedge core_clk)
	begin
		if (inPort.valid && !full)
			store[wrPtr[PW-1:0]] <= inPort.data;
	end

	// write pointer
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			wrPtr <= '0;
		else if (inPort.valid && !full)
			wrPtr <= wrPtr + 1'b1;
	end

	// read pointer
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			rdPtr <= '0;
		else if (outPort.ready && !empty)
			rdPtr <= rdPtr + 1'b1;
	end
endmodule

//--- ssb_burst_ctr.sv
// two-bit burst sequencer, linear or interleaved, wrapping after four
`timescale 1ns/1ps
module ssb_burst_ctr import ssb_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// control
	input wire logic load,
	input wire logic step,
	input wire logic interleaved,
	input wire logic [BURST_W-1:0] base,
	// low address bits of the next access
	output logic [BURST_W-1:0] stepLow
);
	logic [BURST_W-1:0] startLow;
	logic [BURST_W-1:0] count;
	logic [BURST_W-1:0] next_count;

	assign next_count = count + 1'b1;
	// interleaved order flips bits of the start, linear order adds
	assign stepLow = interleaved ? (startLow ^ next_count) : (startLow + next_count);

	// start address and step count
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			startLow <= '0;
			count <= '0;
		end
		else if (load)
		begin
			startLow <= base;
			count <= '0;
		end
		else if (step)
			count <= next_count;
	end
endmodule

//--- ssb_ctrl_model.sv
// behavioural memory controller that drives the burst sram bus
`timescale 1ns/1ps
module ssb_ctrl_model import ssb_pkg::*; #(
	parameter int AW = 6
) (
	// clock
	input wire logic core_clk,
	// controls
	output logic [AW-1:0] address,
	output logic chipSel1N,
	output logic chipSel2,
	output logic chipSel3N,
	output logic advanceOrLoad,
	output logic writeEnableN,
	output logic [DEF_LANES-1:0] byteLaneWriteN,
	output logic outputEnableN,
	output logic clockQualifyN,
	output logic sleepRequest,
	output logic burstOrder,
	// write data towards the shared lanes
	output logic [DEF_LANES*LANE_W-1:0] ctrlData,
	output logic [DEF_LANES-1:0] ctrlPar,
	output logic ctrlDrive
);
	// two slots of {valid, parity, data}; write data trails its address edge
	logic [36:0] slot0;
	logic [36:0] slot1;
	logic inWrite;

	// power up idle and deselected
	initial
	begin
		{address, advanceOrLoad, writeEnableN, burstOrder} = '0;
		{ctrlData, ctrlPar, ctrlDrive, slot0, slot1, inWrite} = '0;
		{chipSel1N, chipSel2, chipSel3N} = 3'b101;
		byteLaneWriteN = '1;
		{outputEnableN, clockQualifyN, sleepRequest} = 3'b000;
	end

	// kind: 0 deselect, 1 read load, 2 write load, 3 advance, 4 stall
	task automatic issue(input int kind, input logic [2:0] offSel, input logic [AW-1:0] a,
		input logic [3:0] bw, input logic [31:0] d, input logic [3:0] p);
		logic w;
		@(posedge core_clk);
		if (kind == 4)
		begin
			// a stalled edge moves nothing, the data slots included
			clockQualifyN <= 1'b1;
			return;
		end
		if (kind == 1 || kind == 2 || kind == 0)
			inWrite = (kind == 2) && (offSel == 3'b000);
		w = inWrite && (kind == 2 || kind == 3);
		clockQualifyN <= 1'b0;
		chipSel1N <= (kind == 0) | offSel[0];
		chipSel2 <= (kind != 0) & ~offSel[1];
		chipSel3N <= (kind == 0) | offSel[2];
		advanceOrLoad <= (kind == 3);
		writeEnableN <= (kind != 2);
		address <= a;
		byteLaneWriteN <= bw;
		// lanes driven only in a write data slot, two edges after its address
		{ctrlDrive, ctrlPar, ctrlData} <= slot1;
		slot1 = slot0;
		slot0 = {w, p, d};
	endtask

	// sleep, output enable and burst order; sleep only raised while deselected
	task automatic pins(input logic zz, input logic oeN, input logic order);
		@(posedge core_clk);
		sleepRequest <= zz;
		outputEnableN <= oeN;
		burstOrder <= order;
	endtask
endmodule

//--- test_sync_burst_sram_bus_ops.sv
// self-checking bench for the burst sram bus-operation core
`timescale 1ns/1ps
module test_sync_burst_sram_bus_ops;
	import ssb_pkg::*;
	localparam int AW = 6;
	typedef struct {logic [3:0] bw; logic [31:0] d; logic [3:0] p; logic [35:0] e;} ssb_row_t;
	logic core_clk;
	logic rstn;
	logic [AW-1:0] address;
	logic [AW-1:0] wa;
	logic [AW-1:0] ea;
	logic chipSel1N, chipSel2, chipSel3N, advanceOrLoad, writeEnableN, outputEnableN;
	logic clockQualifyN, sleepRequest, burstOrder, ctrlDrive, dataOe, parityBusOe, sleepActive;
	logic [3:0] byteLaneWriteN, ctrlPar, parityBusOut, parityBusIn, floatPar;
	logic [31:0] ctrlData, dataOut, dataIn, floatData;
	int miscompares = 0;
	int checked = 0;
	// lane writes at one address, each row expecting {parity, data} read back
	ssb_row_t rows [5] = '{
		'{4'h0, 32'h1111_2222, 4'hF, {4'hF, 32'h1111_2222}},
		'{4'hE, 32'hAAAA_AAAA, 4'h0, {4'hE, 32'h1111_22AA}},
		'{4'h7, 32'hBBBB_BBBB, 4'h0, {4'h6, 32'hBB11_22AA}},
		'{4'hF, 32'hCCCC_CCCC, 4'h0, {4'h6, 32'hBB11_22AA}},
		'{4'h9, 32'hCCCC_CCCC, 4'h0, {4'h0, 32'hBBCC_CCAA}}
	};

	// released lanes toggle every cycle so a stale value cannot pass
	assign dataIn = dataOe ? dataOut : (ctrlDrive ? ctrlData : floatData);
	assign parityBusIn = parityBusOe ? parityBusOut : (ctrlDrive ? ctrlPar : floatPar);
	always @(posedge core_clk)
	begin
		floatData <= ~floatData;
		floatPar <= ~floatPar;
	end

	// 40 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	ssb_ctrl_model #(.AW(AW)) i_ctrl (.core_clk(core_clk), .address(address),
		.chipSel1N(chipSel1N), .chipSel2(chipSel2), .chipSel3N(chipSel3N),
		.advanceOrLoad(advanceOrLoad), .writeEnableN(writeEnableN),
		.byteLaneWriteN(byteLaneWriteN), .outputEnableN(outputEnableN),
		.clockQualifyN(clockQualifyN), .sleepRequest(sleepRequest), .burstOrder(burstOrder),
		.ctrlData(ctrlData), .ctrlPar(ctrlPar), .ctrlDrive(ctrlDrive));

	ssb_sram_core #(.ADDR_W(AW), .LANES(4)) i_dut (.core_clk(core_clk), .rstn(rstn),
		.address(address), .chipSel1N(chipSel1N), .chipSel2(chipSel2), .chipSel3N(chipSel3N),
		.advanceOrLoad(advanceOrLoad), .writeEnableN(writeEnableN),
		.byteLaneWriteN(byteLaneWriteN), .outputEnableN(outputEnableN),
		.clockQualifyN(clockQualifyN), .sleepRequest(sleepRequest), .burstOrder(burstOrder),
		.dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .parityBusIn(parityBusIn),
		.parityBusOut(parityBusOut), .parityBusOe(parityBusOe), .sleepActive(sleepActive));

	task automatic check(input logic [37:0] got, input logic [37:0] exp, input string what);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic nop(input int n);
		repeat (n) i_ctrl.issue(0, 3'b000, '0, 4'hF, '0, '0);
	endtask

	// read, two idle ops, then the op that stands beside the returned data
	task automatic rd(input logic [AW-1:0] a, input int nextKind, input logic on,
		input logic [35:0] exp);
		i_ctrl.issue(1, 3'b000, a, 4'h0, 32'h0, 4'h0);
		nop(2);
		i_ctrl.issue(nextKind, 3'b000, a, 4'hF, 32'h0, 4'h0);
		#1;
		if (on)
			check({dataOe, parityBusOe, parityBusOut, dataOut}, {2'b11, exp}, "read");
		else
			check({dataOe, parityBusOe}, 2'b00, "dummy read");
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// a bus fight means the controller drove while the core did
	always @(negedge core_clk)
		if (dataOe === 1'b1 && ctrlDrive === 1'b1)
			check(1'b1, 1'b0, "lane contention");

	// hang guard, far beyond the expected run of some 140 cycles
	initial
	begin
		repeat (3000) @(posedge core_clk);
		miscompares++;
		$display("CHECK FAILED %0t watchdog expired", $time);
		print_verdict();
	end

	// main sequence
	initial
	begin
		rstn = 1'b0;
		floatData = 32'h5A5A_A5A5;
		floatPar = 4'h5;
		repeat (19) @(posedge core_clk);
		#1;
		check({dataOe, parityBusOe, parityBusOut, dataOut}, '0, "reset");
		check(sleepActive, 1'b0, "reset sleep");
		@(posedge core_clk);
		rstn <= 1'b1;
		nop(2);
		foreach (rows[i])
		begin
			i_ctrl.issue(2, 3'b000, 6'h05, rows[i].bw, rows[i].d, rows[i].p);
			nop(2);
			#1;
			check({dataOe, parityBusOe}, 2'b00, "write lanes");
			nop(4);
			rd(6'h05, 0, 1'b1, rows[i].e);
		end
		i_ctrl.pins(1'b0, 1'b1, 1'b0);
		rd(6'h05, 0, 1'b0, '0);
		i_ctrl.pins(1'b0, 1'b0, 1'b0);
		// stalled edges hold data while output enable gates the drivers
		rd(6'h05, 4, 1'b1, rows[4].e);
		i_ctrl.pins(1'b0, 1'b1, 1'b0);
		#1;
		check({dataOe, parityBusOe, parityBusOut, dataOut}, {2'b00, rows[4].e}, "oe off");
		i_ctrl.pins(1'b0, 1'b0, 1'b0);
		#1;
		check({dataOe, parityBusOe, parityBusOut, dataOut}, {2'b11, rows[4].e}, "oe on");
		i_ctrl.pins(1'b1, 1'b0, 1'b0);
		#1;
		check({dataOe, parityBusOe}, 2'b00, "sleep drivers");
		nop(4);
		#1;
		check(sleepActive, 1'b1, "asleep");
		i_ctrl.pins(1'b0, 1'b0, 1'b0);
		nop(4);
		#1;
		check(sleepActive, 1'b0, "awake");
		rd(6'h05, 0, 1'b1, rows[4].e);
		// each select alone off, then an advance while deselected
		for (int k = 0; k < 3; k++)
		begin
			i_ctrl.issue(1, 3'(1 << k), 6'h05, 4'h0, '0, '0);
			i_ctrl.issue(3, 3'b000, 6'h05, 4'h0, '0, '0);
			nop(1);
			repeat (2)
			begin
				nop(1);
				#1;
				check({dataOe, parityBusOe}, 2'b00, "deselected");
			end
		end
		// linear write burst from 10, fifth beat wraps with all strobes high and writes nothing
		for (int j = 0; j < 5; j++)
		begin
			wa = {4'h2, 2'(2 + j)};
			i_ctrl.issue(j == 0 ? 2 : 3, 3'b000, wa, j == 4 ? 4'hF : 4'h0,
				{4{2'b00, wa}} ^ {32{j == 4}}, wa[3:0] ^ {4{j == 4}});
		end
		nop(6);
		i_ctrl.pins(1'b0, 1'b0, 1'b1);
		// interleaved read burst from 9, data returning back to back
		for (int i = 0; i < 7; i++)
		begin
			i_ctrl.issue(i == 0 ? 1 : (i < 4 ? 3 : 0), 3'b000, {4'h2, 2'(1 ^ i)}, 4'h0, '0, '0);
			#1;
			ea = {4'h2, 2'(1 ^ (i - 3))};
			if (i >= 3)
				check({dataOe, parityBusOe, parityBusOut, dataOut},
					{2'b11, ea[3:0], {4{2'b00, ea}}}, "burst read");
		end
		print_verdict();
	end
endmodule
